// File: hdl/ctat_osc_detect.sv
// Detects a running low-power oscillation after reset release.
// Assumes osc_level is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module ctat_osc_detect
  import ctat_pkg::*;
#(
  parameter int DET_CYCLES = CTAT_DET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic osc_level,
  output logic done,
  output logic present
);
  logic [CTAT_DET_W-1:0] timer;
  logic [3:0] edges;
  logic prev;
  wire rise = osc_level & ~prev;
  wire window_end = (timer == CTAT_DET_W'(DET_CYCLES - 1));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer <= '0;
      edges <= 4'h0;
      prev <= 1'b0;
      done <= 1'b0;
      present <= 1'b0;
    end else begin
      prev <= osc_level;
      if (!done) begin
        timer <= timer + 1'b1;
        if (rise && edges != 4'hf) begin
          edges <= edges + 4'h1;
        end
        if (window_end) begin
          done <= 1'b1;
          present <= (edges >= CTAT_DET_EDGES);
        end
      end
    end
  end
endmodule : ctat_osc_detect
`default_nettype wire

// File: hdl/ctat_pkg.sv
// Package for the calendar tick/alarm timer: widths, reset values, timing constants.
// Assumes a single 100 MHz system clock and an asynchronous active-high reset.
package ctat_pkg;
  // ==========================================
  // Widths
  localparam int CTAT_PRE_W = 6;
  localparam int CTAT_DIV_W = 20;
  localparam int CTAT_CNT_W = 32;
  localparam int CTAT_CYC_W = 16;
  localparam int CTAT_LONG_W = CTAT_PRE_W + CTAT_DIV_W + CTAT_CNT_W;
  // ==========================================
  // Fixed divide-by-64 stage
  localparam logic [CTAT_PRE_W-1:0] CTAT_PRE_LAST = 6'h3f;
  // ==========================================
  // Reset values
  localparam logic [CTAT_DIV_W-1:0] CTAT_DIV_RESET = 20'h00000;
  localparam logic [CTAT_CNT_W-1:0] CTAT_CNT_RESET = 32'h00000000;
  localparam logic [CTAT_CYC_W-1:0] CTAT_CYC_RESET = 16'h0000;
  // ==========================================
  // Oscillation detection: edges needed on the low-power input within a window
  localparam int CTAT_DET_WINDOW_US = 200;
  localparam int CTAT_CLK_MHZ = 100;
  localparam int CTAT_DET_CYCLES = CTAT_DET_WINDOW_US * CTAT_CLK_MHZ;
  localparam logic [3:0] CTAT_DET_EDGES = 4'h4;
  localparam int CTAT_DET_W = 16;
  // ==========================================
  // Clock source
  typedef enum logic {CTAT_SRC_MAIN, CTAT_SRC_LOWPOWER} ctat_src_t;
endpackage : ctat_pkg

// File: hdl/ctat_sync.sv
// Two-flip-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
`default_nettype none
module ctat_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ctat_sync
`default_nettype wire

// File: hdl/ctat_top.sv
// Calendar tick/alarm timer: prescaler, 20-bit reload divider, 32-bit time counter,
// alarm compare, tick and cyclic requests, oscillator control for power-down.
// Assumes the timebase inputs are pin levels sampled on clk; control bits are plain ports
// fed by the register logic on the peripheral bus outside this module.
// Function
// (R1) Count from main or low-power oscillator, independent of CPU clock gating.
// (R2) After reset, detect low-power oscillation; select it if present, else main.
// (R3) A fixed divide-by-64 stage feeds the 20-bit reference divider.
// (R4) The 20-bit divider reloads from the prescaler reload value every period.
// (R5) The reload value alone sets the length of one basic tick; code: the first tick after reset is 64 edges, as div resets to zero.
// (R6) Tick request fires once per basic period when enabled.
// (R7) Cyclic request fires after n programmable basic ticks when enabled.
// (R8) 32-bit time counter increments per tick and can be preloaded.
// (R9) Time counter is compared continuously with the 32-bit alarm value.
// (R10) Alarm request raised on equality when alarm request enabled.
// (R11) Tick and alarm requests feed the external interrupt source selection.
// (R12) With wake configuration set, wake the chip after programmed delay.
// (R13) Control bit lets software stop the oscillator in power-down.
// (R14) Block disabled and power-down: stop both oscillators.
// (R15) Low-power source: power-down always stops main oscillator; counter per config.
// (R16) Main source, block enabled: main oscillator stays on in power-down; code keeps it on only while osc_stop_in_powerdown is clear.
// (R17) Prescaler, divider and counter readable together as one 58-bit timer.
// (R18) Registers are reached only through the on-chip peripheral bus.
// (R19) Alarm evaluated once per counter update, one request per match.
`timescale 1ns/10ps
`default_nettype none
module ctat_top
  import ctat_pkg::*;
#(
  parameter int DET_CYCLES = CTAT_DET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic main_osc_input,
  input wire logic lowpower_osc_input,
  // Control bits come from the bus register logic outside this block; see (R18)
  input wire logic enable,
  input wire logic powerdown,
  input wire logic osc_stop_in_powerdown,
  input wire logic powerdown_wake_config,
  input wire logic tick_irq_enable,
  input wire logic alarm_irq_enable,
  input wire logic cyclic_irq_enable,
  input wire logic [CTAT_DIV_W-1:0] tick_prescaler_reload,
  input wire logic [CTAT_CYC_W-1:0] cyclic_count,
  input wire logic counter_load,
  input wire logic [CTAT_CNT_W-1:0] counter_load_value,
  input wire logic [CTAT_CNT_W-1:0] alarm_value,
  output logic tick_irq_request,
  output logic alarm_irq_request,
  output logic cyclic_irq_request,
  output logic powerdown_wake,
  output logic main_osc_on,
  output logic lowpower_osc_on,
  output logic source_lowpower,
  output logic source_valid,
  output logic [CTAT_LONG_W-1:0] long_timer
);
  // ==========================================
  // Timebase inputs
  logic main_s;
  logic lp_s;
  logic base_prev;
  logic det_done;
  logic det_present;
  ctat_src_t src;

  ctat_sync u_sync_main (
    .clk(clk),
    .reset(reset),
    .d(main_osc_input),
    .q(main_s)
  );

  ctat_sync u_sync_lp (
    .clk(clk),
    .reset(reset),
    .d(lowpower_osc_input),
    .q(lp_s)
  );

  ctat_osc_detect #(
    .DET_CYCLES(DET_CYCLES)
  ) u_detect (
    .clk(clk),
    .reset(reset),
    .osc_level(lp_s),
    .done(det_done),
    .present(det_present)
  );

  function automatic logic is_lowpower(input ctat_src_t s);
    return s == CTAT_SRC_LOWPOWER;
  endfunction : is_lowpower

  // ==========================================
  // Source selection
  logic det_done_q;
  ctat_src_t next_src;
  wire det_done_rise = det_done & ~det_done_q;
  wire src_is_lowpower = is_lowpower(src);
  wire src_is_main = ~src_is_lowpower;
  assign next_src = det_present ? CTAT_SRC_LOWPOWER : CTAT_SRC_MAIN;

  // Source chosen once per reset, at the end of the detection window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src <= CTAT_SRC_MAIN;
    end else if (det_done_rise) begin
      src <= next_src; // see (R2)
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      det_done_q <= 1'b0;
    end else begin
      det_done_q <= det_done;
    end
  end

  // ==========================================
  // Selected timebase
  // Edge of the selected oscillator; not gated by any CPU clock enable
  wire base_level = src_is_lowpower ? lp_s : main_s; // see (R1)
  wire base_edge = base_level & ~base_prev;

  // Counting starts a cycle after the source switch, so the switch itself
  // cannot pass for an edge of the newly selected oscillator
  wire counter_stopped = powerdown & osc_stop_in_powerdown; // see (R13) see (R15)
  wire run = enable & source_valid & ~counter_stopped; // see (R14)

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base_prev <= 1'b0;
    end else begin
      base_prev <= base_level;
    end
  end

  // ==========================================
  // Divider chain
  logic [CTAT_PRE_W-1:0] pre;
  logic [CTAT_DIV_W-1:0] div;
  logic [CTAT_CNT_W-1:0] count;
  logic [CTAT_CYC_W-1:0] cyc;

  wire pre_wrap = run & base_edge & (pre == CTAT_PRE_LAST); // see (R3)
  wire div_end = pre_wrap & (div == CTAT_DIV_RESET);
  wire cyc_end = div_end & (cyc == CTAT_CYC_RESET);
  wire [CTAT_CNT_W-1:0] next_count = counter_load ? counter_load_value
                                     : (div_end ? count + 1'b1 : count);
  wire count_updated = counter_load | div_end;
  wire alarm_match = (next_count == alarm_value); // see (R9)

  wire [CTAT_DIV_W-1:0] next_div = div_end ? tick_prescaler_reload : div - 1'b1;
  wire [CTAT_CYC_W-1:0] next_cyc = cyc_end ? cyclic_count : cyc - 1'b1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre <= '0;
    end else if (run & base_edge) begin
      pre <= pre + 1'b1; // see (R3)
    end
  end

  // Reload value sets the tick period: reload+1 prescaled clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div <= CTAT_DIV_RESET;
    end else if (pre_wrap) begin
      div <= next_div; // see (R4) see (R5)
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= CTAT_CNT_RESET;
    end else begin
      count <= next_count; // see (R8)
    end
  end

  // A cyclic count of n gives one cyclic event every n+1 ticks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cyc <= CTAT_CYC_RESET;
    end else if (div_end) begin
      cyc <= next_cyc; // see (R7)
    end
  end

  // ==========================================
  // Requests and oscillator control
  wire alarm_event = count_updated & alarm_match & alarm_irq_enable; // see (R10) see (R19)
  wire cyclic_event = cyc_end & cyclic_irq_enable; // see (R7)
  wire wake_event = powerdown & powerdown_wake_config & (cyclic_event | alarm_event); // see (R12)
  // Low-power source: main always off in power-down; main source keeps it if enabled and osc_stop_in_powerdown is clear
  wire next_main_osc_on = ~powerdown | (src_is_main & enable & ~osc_stop_in_powerdown);
  wire next_lowpower_osc_on = ~powerdown | (src_is_lowpower & enable & ~osc_stop_in_powerdown);

  // One-cycle pulses for the port-2 external interrupt selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_irq_request <= 1'b0;
      alarm_irq_request <= 1'b0;
      cyclic_irq_request <= 1'b0;
    end else begin
      tick_irq_request <= div_end & tick_irq_enable; // see (R6) see (R11)
      alarm_irq_request <= alarm_event; // see (R10) see (R11) see (R19)
      cyclic_irq_request <= cyclic_event; // see (R7)
    end
  end

  // Wake delay is the cyclic or alarm event; no separate delay counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      powerdown_wake <= 1'b0;
    end else begin
      powerdown_wake <= wake_event; // see (R12)
    end
  end

  // Oscillators reset to on, so detection always has a running clock to look at
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_osc_on <= 1'b1;
      lowpower_osc_on <= 1'b1;
    end else begin
      main_osc_on <= next_main_osc_on; // see (R14) see (R15) see (R16)
      lowpower_osc_on <= next_lowpower_osc_on; // see (R13) see (R14)
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      source_lowpower <= 1'b0;
      source_valid <= 1'b0;
      long_timer <= '0;
    end else begin
      source_lowpower <= src_is_lowpower; // see (R2)
      source_valid <= det_done_q;
      long_timer <= {count, div, pre}; // see (R17)
    end
  end

  // ==========================================
  // Checks
  AST_TICK_ONLY_ENABLED: assert property (@(posedge clk) disable iff (reset)
    tick_irq_request |-> $past(tick_irq_enable)) // see (R6)
    else $error("tick request while disabled");
  AST_COUNT_INC: assert property (@(posedge clk) disable iff (reset)
    (div_end & ~counter_load) |=> count == $past(count) + 32'h1) // see (R8)
    else $error("time counter did not step on tick");
  AST_COUNT_LOAD: assert property (@(posedge clk) disable iff (reset)
    counter_load |=> count == $past(counter_load_value)) // see (R8)
    else $error("preload lost");
  AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
    div_end |=> div == $past(tick_prescaler_reload)) // see (R4)
    else $error("divider not reloaded");
  AST_ALARM: assert property (@(posedge clk) disable iff (reset)
    (count_updated & alarm_match & alarm_irq_enable) |=> alarm_irq_request ##1 !alarm_irq_request) // see (R10)
    else $error("alarm request wrong");
  AST_ALARM_ONCE: assert property (@(posedge clk) disable iff (reset)
    alarm_irq_request |-> $past(count_updated)) // see (R19)
    else $error("alarm repeated without update");
  AST_PRE_STEP: assert property (@(posedge clk) disable iff (reset)
    (div != $past(div)) |-> $past(pre) == CTAT_PRE_LAST) // see (R3)
    else $error("divider moved off prescaler wrap");
  AST_MAIN_OFF_LP: assert property (@(posedge clk) disable iff (reset)
    (powerdown & src == CTAT_SRC_LOWPOWER) |=> !main_osc_on) // see (R15)
    else $error("main oscillator left on");
  AST_ALL_OFF: assert property (@(posedge clk) disable iff (reset)
    (powerdown & ~enable) |=> !main_osc_on && !lowpower_osc_on) // see (R14)
    else $error("oscillator on while disabled in power-down");
  AST_MAIN_KEPT: assert property (@(posedge clk) disable iff (reset)
    (powerdown & enable & ~osc_stop_in_powerdown & src == CTAT_SRC_MAIN) |=> main_osc_on) // see (R16)
    else $error("main oscillator stopped");
  AST_CYCLIC_ONLY_ENABLED: assert property (@(posedge clk) disable iff (reset)
    cyclic_irq_request |-> $past(cyclic_irq_enable)) // see (R7)
    else $error("cyclic request while disabled");
  AST_ALARM_ONLY_ENABLED: assert property (@(posedge clk) disable iff (reset)
    alarm_irq_request |-> $past(alarm_irq_enable)) // see (R10)
    else $error("alarm request while disabled");
  AST_ALARM_EQUAL: assert property (@(posedge clk) disable iff (reset)
    alarm_irq_request |-> count == $past(alarm_value)) // see (R9)
    else $error("alarm request without match");
  AST_WAKE_CONFIG: assert property (@(posedge clk) disable iff (reset)
    powerdown_wake |-> $past(powerdown & powerdown_wake_config)) // see (R12)
    else $error("wake without power-down wake setting");
  AST_WAKE_EVENT: assert property (@(posedge clk) disable iff (reset)
    powerdown_wake |-> (cyclic_irq_request | alarm_irq_request)) // see (R12)
    else $error("wake without cyclic or alarm event");
  AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (reset)
    (powerdown & osc_stop_in_powerdown) |=> pre == $past(pre)) // see (R13)
    else $error("prescaler moved while stopped");
  AST_HOLD_DISABLED: assert property (@(posedge clk) disable iff (reset)
    ~enable |=> pre == $past(pre) && div == $past(div)) // see (R1)
    else $error("divider chain moved while disabled");
  AST_SOURCE_HELD: assert property (@(posedge clk) disable iff (reset)
    $past(source_valid) |-> $stable(source_lowpower)) // see (R2)
    else $error("source changed after detection");
  AST_TICK_AFTER_DETECT: assert property (@(posedge clk) disable iff (reset)
    tick_irq_request |-> $past(source_valid)) // see (R2)
    else $error("tick before source detection done");
endmodule : ctat_top
`default_nettype wire

// File: sim/ctat_top_tb.sv
// Self-checking bench for the calendar tick/alarm timer top.
// Assumes the ctat_pkg package is compiled first; drives all ports directly.
`timescale 1ns/10ps
`default_nettype none
module ctat_top_tb;
  import ctat_pkg::*;
  typedef struct {logic [CTAT_DIV_W-1:0] reload; int edges;} ctat_row_t;
  logic clk, reset, main_osc_input, lowpower_osc_input, enable, powerdown, osc_stop_in_powerdown;
  logic powerdown_wake_config, tick_irq_enable, alarm_irq_enable, cyclic_irq_enable, counter_load;
  logic [CTAT_DIV_W-1:0] tick_prescaler_reload;
  logic [CTAT_CYC_W-1:0] cyclic_count;
  logic [CTAT_CNT_W-1:0] counter_load_value, alarm_value;
  logic tick_irq_request, alarm_irq_request, cyclic_irq_request, powerdown_wake;
  logic main_osc_on, lowpower_osc_on, source_lowpower, source_valid;
  logic [CTAT_LONG_W-1:0] long_timer;
  logic lp_run;
  int mismatches, samples_checked, ticks, alarms, cycs, wakes, n, a0, c0, w0, cnt;
  ctat_row_t rows [3] = '{'{20'h00000, 64}, '{20'h00001, 128}, '{20'h00003, 256}};
  // Short detection window keeps the run brief
  ctat_top #(.DET_CYCLES(50)) ctat_top_inst (.*);
  // ==========================================
  // Clock, low-power oscillator, event counters
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    forever begin
      @(posedge clk) #1;
      if (lp_run) lowpower_osc_input = ~lowpower_osc_input;
    end
  end
  always @(posedge clk) begin
    if (tick_irq_request === 1'b1) ticks++;
    if (alarm_irq_request === 1'b1) alarms++;
    if (cyclic_irq_request === 1'b1) cycs++;
    if (powerdown_wake === 1'b1) wakes++;
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // One source edge, long enough to clear the synchroniser and its tick
  task automatic edge1();
    main_osc_input = 1'b1;
    repeat (3) @(posedge clk);
    #1 main_osc_input = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : edge1
  task automatic to_tick(output int k);
    int t0;
    t0 = ticks;
    k = 0;
    while (ticks == t0 && k < 1000) begin
      edge1();
      k++;
    end
    if (ticks == t0) begin
      mismatches++;
      summarize();
    end
  endtask : to_tick
  task automatic do_reset();
    int k;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check({tick_irq_request, alarm_irq_request, cyclic_irq_request, powerdown_wake,
           main_osc_on, lowpower_osc_on, source_lowpower, source_valid}, 8'h0c);
    check(long_timer, 58'h0);
    reset = 1'b0;
    for (k = 0; k < 200 && source_valid !== 1'b1; k++) @(posedge clk);
    #1;
    if (source_valid !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : do_reset
  // ==========================================
  // Main sequence
  initial begin
    {reset, main_osc_input, lowpower_osc_input, powerdown, osc_stop_in_powerdown, lp_run} = '0;
    {powerdown_wake_config, alarm_irq_enable, cyclic_irq_enable, counter_load} = '0;
    enable = 1'b1;
    tick_irq_enable = 1'b1;
    tick_prescaler_reload = 20'h00002;
    cyclic_count = 16'h0001;
    counter_load_value = 32'h00000010;
    alarm_value = 32'h00000011;
    do_reset();
    check(source_lowpower, 1'b0);
    // Divider starts at zero, so the first tick ignores the reload value
    to_tick(n);
    check(n, 64);
    cnt = 1;
    for (int i = 0; i < 3; i++) begin
      tick_prescaler_reload = rows[i].reload;
      to_tick(n);
      to_tick(n);
      cnt += 2;
      check(n, rows[i].edges);
      check(long_timer, {cnt[31:0], rows[i].reload, 6'h00});
    end
    // Alarm fires once on the matching update only
    tick_prescaler_reload = 20'h00000;
    alarm_irq_enable = 1'b1;
    counter_load = 1'b1;
    @(posedge clk) #1 counter_load = 1'b0;
    a0 = alarms;
    to_tick(n);
    check(alarms - a0, 1);
    to_tick(n);
    check(alarms - a0, 1);
    check(long_timer[CTAT_LONG_W-1 -: CTAT_CNT_W], 32'h00000012);
    // A preload straight onto the alarm value is an update and raises the alarm
    counter_load_value = 32'h00000011;
    counter_load = 1'b1;
    @(posedge clk) #1 counter_load = 1'b0;
    @(posedge clk) #1;
    check(alarms - a0, 2);
    // Cyclic request every two ticks waking the chip, main oscillator kept on
    cyclic_irq_enable = 1'b1;
    powerdown = 1'b1;
    powerdown_wake_config = 1'b1;
    c0 = cycs;
    w0 = wakes;
    repeat (4) to_tick(n);
    check(cycs - c0, 2);
    check(wakes - w0, 2);
    check(main_osc_on, 1'b1);
    // Stopped in power-down: edges ignored, oscillator off
    osc_stop_in_powerdown = 1'b1;
    n = ticks;
    repeat (100) edge1();
    check(ticks - n, 0);
    check(main_osc_on, 1'b0);
    osc_stop_in_powerdown = 1'b0;
    enable = 1'b0;
    repeat (100) edge1();
    check(ticks - n, 0);
    check({main_osc_on, lowpower_osc_on}, 2'h0);
    // Second reset with the low-power oscillation running
    lp_run = 1'b1;
    do_reset();
    check(source_lowpower, 1'b1);
    enable = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({main_osc_on, lowpower_osc_on}, 2'h1);
    summarize();
  end
endmodule : ctat_top_tb
`default_nettype wire
